// [rtl/usbmc_top.sv]
/*
 * Module-control logic of a USB device serial interface engine:
 * enable/soft attach, ping-pong pointer reset, live SE0 flag, packet
 * transfer disable, resume signalling, suspend and interrupt status.
 * Assumes one 40 MHz clock, firmware on AXI4-Lite, and that the engine
 * pulses setup_token for one aclk cycle per received SETUP token.
 */
// The AXI4-Lite slave port was decided locally.
// Functional notes
// - Control bit 5 reads 1 while SE0 is present on the bus.
// - Setting enable (bit 3) starts engine, clears ping-pong indicators.
// - Enable switches on the pull-ups when their own enable is set.
// - With enable clear, all other bits are ignored; module detached.
// - Bit 6 set holds all ping-pong pointers on even bank until cleared.
// - Bit 6 has no effect when ping-pong buffering is off.
// - A SETUP token sets the transfer-disable flag, bit 4, halting packets.
// - Software may clear the transfer-disable flag but never set it.
// - Pending descriptor events stay reported while packets are halted.
// - Bit 2 set drives resume signalling; clearing it stops it.
// - Suspend (bit 1) enters power-conserve and stops the engine clock.
// - While suspended, stay attached with transceiver outputs idle; xcvr_idle drops while resume (bit 2) is also set.
// - Bits 7 and 0 read 0; writable bits and flag reset to 0.
`timescale 1ns/1ps
`default_nettype none

module usbmc_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic se0_line,
    input wire logic setup_token,
    output logic engine_enable,
    output logic pullup_on,
    output logic bd_pingpong_indicator_clear,
    output logic pp_hold_even,
    output logic pkt_halt,
    output logic stat_fifo_retain,
    output logic resume_drive,
    output logic engine_clk_run,
    output logic xcvr_idle,
    output logic irq
);

    logic wr_en;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [15:0] rd_addr;
    logic [31:0] rd_word;
    logic rd_ok;
    logic se0_s;
    logic se0_prev_q;
    logic en_q, en_d, susp_q, susp_d, resume_q, resume_d;
    logic pprst_q, pprst_d, packet_transfer_disable_q, packet_transfer_disable_d;
    logic [usbmc_pkg::CFG_W-1:0] cfg_q, cfg_d;
    logic [usbmc_pkg::IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, evt;
    logic pullup_q, pullup_d, ppclr_q, ppclr_d, pphold_q, pphold_d;
    logic halt_q, halt_d, retain_q, retain_d, resdrv_q, resdrv_d;
    logic clkrun_q, clkrun_d, idle_q, idle_d, irq_q, irq_d;
    logic ctrl_wr, stat_wr, mask_wr, cfg_wr;

    // Address decoding shared by the write and read paths
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    function automatic logic mapped(input logic [15:0] a);
        mapped = hit(a, usbmc_pkg::CTRL_ADDR)
               || hit(a, usbmc_pkg::IRQ_STAT_ADDR)
               || hit(a, usbmc_pkg::IRQ_MASK_ADDR)
               || hit(a, usbmc_pkg::CFG_ADDR);
    endfunction

    // ---------------------------------------------------------------
    // Bus front end and pin synchroniser
    // ---------------------------------------------------------------
    usbmc_axil u_axil
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_addr(rd_addr),
        .rd_word(rd_word),
        .rd_ok(rd_ok)
    );

    // Bus lines are asynchronous to aclk; never read them raw
    usbmc_sync u_se0_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(se0_line),
        .sync_out(se0_s)
    );

    // ---------------------------------------------------------------
    // Register access decode
    // ---------------------------------------------------------------
    // Only byte lane 0 carries implemented bits
    assign wr_ok = mapped(wr_addr);
    assign rd_ok = mapped(rd_addr);
    assign ctrl_wr = wr_en && hit(wr_addr, usbmc_pkg::CTRL_ADDR) && wr_strb[0];
    assign stat_wr = wr_en && hit(wr_addr, usbmc_pkg::IRQ_STAT_ADDR)
                     && wr_strb[0];
    assign mask_wr = wr_en && hit(wr_addr, usbmc_pkg::IRQ_MASK_ADDR)
                     && wr_strb[0];
    assign cfg_wr = wr_en && hit(wr_addr, usbmc_pkg::CFG_ADDR) && wr_strb[0];

    // Read mux; unimplemented bits and upper lanes read zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (hit(rd_addr, usbmc_pkg::CTRL_ADDR))
        begin
            rd_word[usbmc_pkg::PPRST_BIT] = pprst_q;
            rd_word[usbmc_pkg::SE0_BIT] = se0_s;
            rd_word[usbmc_pkg::PACKET_TRANSFER_DISABLE_BIT] = packet_transfer_disable_q;
            rd_word[usbmc_pkg::EN_BIT] = en_q;
            rd_word[usbmc_pkg::RESUME_BIT] = resume_q;
            rd_word[usbmc_pkg::SUSP_BIT] = susp_q; // 7 and 0 stay 0
        end
        else if (hit(rd_addr, usbmc_pkg::IRQ_STAT_ADDR))
            rd_word[usbmc_pkg::IRQ_W-1:0] = stat_q;
        else if (hit(rd_addr, usbmc_pkg::IRQ_MASK_ADDR))
            rd_word[usbmc_pkg::IRQ_W-1:0] = mask_q;
        else if (hit(rd_addr, usbmc_pkg::CFG_ADDR))
            rd_word[usbmc_pkg::CFG_W-1:0] = cfg_q;
    end

    // ---------------------------------------------------------------
    // Control, status and derived outputs
    // ---------------------------------------------------------------
    // Hardware set beats software clear on every sticky flag
    always_comb
    begin
        en_d = en_q;
        susp_d = susp_q;
        resume_d = resume_q;
        pprst_d = pprst_q;
        packet_transfer_disable_d = packet_transfer_disable_q;
        cfg_d = cfg_q;
        mask_d = mask_q;
        stat_d = stat_q;
        if (ctrl_wr)
        begin
            en_d = wr_data[usbmc_pkg::EN_BIT];
            susp_d = wr_data[usbmc_pkg::SUSP_BIT];
            resume_d = wr_data[usbmc_pkg::RESUME_BIT];
            pprst_d = wr_data[usbmc_pkg::PPRST_BIT]; // Held until cleared
            if (!wr_data[usbmc_pkg::PACKET_TRANSFER_DISABLE_BIT])
                packet_transfer_disable_d = 1'b0; // Writing one never sets it
        end
        if (setup_token && en_q)
            packet_transfer_disable_d = 1'b1;
        if (cfg_wr)
            cfg_d = wr_data[usbmc_pkg::CFG_W-1:0];
        if (mask_wr)
            mask_d = wr_data[usbmc_pkg::IRQ_W-1:0];
        evt = '0;
        evt[usbmc_pkg::IRQ_SETUP_BIT] = setup_token && en_q;
        evt[usbmc_pkg::IRQ_SE0_BIT] = se0_s && !se0_prev_q && en_q;
        if (stat_wr)
            stat_d = stat_d & ~wr_data[usbmc_pkg::IRQ_W-1:0];
        stat_d = stat_d | evt;
        // Every effect but irq is gated by enable, so a disabled module drives only irq
        pullup_d = en_d && cfg_d[usbmc_pkg::CFG_PULLUP_BIT];
        ppclr_d = en_d && !en_q; // One pulse on enable rising
        pphold_d = en_d && pprst_d
                   && (cfg_d[usbmc_pkg::CFG_PPB_LO +: 2]
                       != usbmc_pkg::PPB_OFF);
        halt_d = en_d && packet_transfer_disable_d;
        retain_d = en_d && packet_transfer_disable_d; // Status FIFO is not flushed
        resdrv_d = en_d && resume_d;
        clkrun_d = en_d && !susp_d;
        idle_d = en_d && susp_d && !resume_d; // Attached, drivers idle
        irq_d = |(stat_d & mask_d);
    end

    // Register stage; every engine-side top output comes straight from these flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            en_q <= 1'b0;
            susp_q <= 1'b0;
            resume_q <= 1'b0;
            pprst_q <= 1'b0;
            packet_transfer_disable_q <= 1'b0;
            cfg_q <= usbmc_pkg::CFG_RST;
            mask_q <= usbmc_pkg::IRQ_RST;
            stat_q <= usbmc_pkg::IRQ_RST;
            se0_prev_q <= 1'b0;
            pullup_q <= 1'b0;
            ppclr_q <= 1'b0;
            pphold_q <= 1'b0;
            halt_q <= 1'b0;
            retain_q <= 1'b0;
            resdrv_q <= 1'b0;
            clkrun_q <= 1'b0;
            idle_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            en_q <= en_d;
            susp_q <= susp_d;
            resume_q <= resume_d;
            pprst_q <= pprst_d;
            packet_transfer_disable_q <= packet_transfer_disable_d;
            cfg_q <= cfg_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            se0_prev_q <= se0_s;
            pullup_q <= pullup_d;
            ppclr_q <= ppclr_d;
            pphold_q <= pphold_d;
            halt_q <= halt_d;
            retain_q <= retain_d;
            resdrv_q <= resdrv_d;
            clkrun_q <= clkrun_d;
            idle_q <= idle_d;
            irq_q <= irq_d;
        end
    end

    assign engine_enable = en_q;
    assign pullup_on = pullup_q;
    assign bd_pingpong_indicator_clear = ppclr_q;
    assign pp_hold_even = pphold_q;
    assign pkt_halt = halt_q;
    assign stat_fifo_retain = retain_q;
    assign resume_drive = resdrv_q;
    assign engine_clk_run = clkrun_q;
    assign xcvr_idle = idle_q;
    assign irq = irq_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Halt follows the flag only while enabled, even if disabled meanwhile
    chk_setup_sets_halt: assert property (
        setup_token && en_q |=> packet_transfer_disable_q && pkt_halt == en_q)
        else $error("SETUP did not set the transfer-disable flag");
    chk_packet_transfer_disable_no_sw_set: assert property (
        !packet_transfer_disable_q && !(setup_token && en_q) |=> !packet_transfer_disable_q)
        else $error("Transfer-disable flag set without a SETUP");
    chk_enable_clears_pingpong_indicator: assert property (
        $rose(en_q) |-> bd_pingpong_indicator_clear ##1 !bd_pingpong_indicator_clear)
        else $error("Indicator clear pulse missing on enable");
    chk_pp_hold_mode: assert property (
        pp_hold_even |-> en_q && pprst_q
        && cfg_q[usbmc_pkg::CFG_PPB_LO +: 2] != usbmc_pkg::PPB_OFF)
        else $error("Pointer hold without reset bit or ping-pong mode");
    chk_pp_hold_held: assert property (
        en_q && pprst_q
        && cfg_q[usbmc_pkg::CFG_PPB_LO +: 2] != usbmc_pkg::PPB_OFF
        |-> pp_hold_even)
        else $error("Pointer hold released while reset bit set");
    chk_disabled_inert: assert property (
        !en_q |-> !pullup_on && !resume_drive && !pkt_halt
        && !engine_clk_run && !xcvr_idle)
        else $error("Outputs active while module disabled");
    chk_pullup_attach: assert property (
        en_q && cfg_q[usbmc_pkg::CFG_PULLUP_BIT] |-> pullup_on)
        else $error("Pull-up off while enabled and allowed");
    chk_resume_drive: assert property (
        $fell(resume_q) |-> !resume_drive)
        else $error("Resume signalling outlived the resume bit");
    chk_suspend_gate: assert property (
        en_q && susp_q |-> !engine_clk_run
        && pullup_on == cfg_q[usbmc_pkg::CFG_PULLUP_BIT])
        else $error("Suspend did not stop engine clock or detached");
    chk_se0_flag: assert property (
        se0_line [*3] |-> se0_s)
        else $error("Live SE0 flag not following the bus");
    chk_ctrl_zero_bits: assert property (
        hit(rd_addr, usbmc_pkg::CTRL_ADDR)
        |-> rd_word[7] == 1'b0 && rd_word[0] == 1'b0)
        else $error("Unimplemented control bits read nonzero");

endmodule

`default_nettype wire

// [rtl/usbmc_pkg.sv]
/*
 * Constants shared by the module-control block: register indexes and
 * byte addresses, field positions, reset values and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with 16-bit byte addresses.
 */
package usbmc_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    // Register indexes; byte address is four times the index
    localparam logic [11:0] CTRL_IDX = 12'hf65;
    localparam logic [11:0] IRQ_STAT_IDX = 12'hf66;
    localparam logic [11:0] IRQ_MASK_IDX = 12'hf67;
    localparam logic [11:0] CFG_IDX = 12'hf68;
    localparam logic [15:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [15:0] IRQ_STAT_ADDR = {2'h0, IRQ_STAT_IDX, 2'h0};
    localparam logic [15:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_IDX, 2'h0};
    localparam logic [15:0] CFG_ADDR = {2'h0, CFG_IDX, 2'h0};

    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int unsigned SUSP_BIT = 1;
    localparam int unsigned RESUME_BIT = 2;
    localparam int unsigned EN_BIT = 3;
    localparam int unsigned PACKET_TRANSFER_DISABLE_BIT = 4;
    localparam int unsigned SE0_BIT = 5;
    localparam int unsigned PPRST_BIT = 6;

    // ---------------------------------------------------------------
    // Interrupt and configuration fields
    // ---------------------------------------------------------------
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_SETUP_BIT = 0;
    localparam int unsigned IRQ_SE0_BIT = 1;
    localparam int unsigned CFG_PULLUP_BIT = 0;
    localparam int unsigned CFG_PPB_LO = 1;
    localparam int unsigned CFG_W = 3;
    localparam logic [1:0] PPB_OFF = 2'h0;

    // ---------------------------------------------------------------
    // Reset values and bus answers
    // ---------------------------------------------------------------
    localparam logic [CFG_W-1:0] CFG_RST = 3'h0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rtl/usbmc_sync.sv]
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the input is quasi-static relative to aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module usbmc_sync
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;
    logic sync_q;

    // ---------------------------------------------------------------
    // Synchroniser chain
    // ---------------------------------------------------------------
    // First stage feeds only the second stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

`default_nettype wire

// [rtl/usbmc_axil.sv]
/*
 * AXI4-Lite slave front end: one write and one read in flight at most.
 * Assumes the parent decodes wr_addr/rd_addr and returns validity and
 * read data combinationally from its own registers.
 */
`timescale 1ns/1ps
`default_nettype none

module usbmc_axil
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [15:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [15:0] rd_addr,
    input wire logic [31:0] rd_word,
    input wire logic rd_ok
);

    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [15:0] awaddr_q, awaddr_d, araddr_q, araddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic arready_q, arready_d, rpend_q, rpend_d, rvalid_q, rvalid_d;

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    // Address and data are latched independently, in either order
    always_comb
    begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        wr_en = aw_have_q && w_have_q && !bvalid_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_en)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_ok ? usbmc_pkg::RESP_OKAY : usbmc_pkg::RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        // Ready drops while a response is pending, no second write
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        // Read: address cycle, one decode cycle, then answer
        arready_d = arready_q;
        araddr_d = araddr_q;
        rpend_d = 1'b0;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && arready_q)
        begin
            arready_d = 1'b0;
            araddr_d = s_axi_araddr;
            rpend_d = 1'b1;
        end
        if (rpend_q)
        begin
            rvalid_d = 1'b1;
            rdata_d = rd_ok ? rd_word : 32'h0000_0000;
            rresp_d = rd_ok ? usbmc_pkg::RESP_OKAY : usbmc_pkg::RESP_SLVERR;
        end
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // State registers
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            awaddr_q <= 16'h0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            arready_q <= 1'b1;
            araddr_q <= 16'h0000;
            rpend_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            arready_q <= arready_d;
            araddr_q <= araddr_d;
            rpend_q <= rpend_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign wr_addr = awaddr_q;
    assign wr_data = wdata_q;
    assign wr_strb = wstrb_q;
    assign rd_addr = araddr_q;

endmodule

`default_nettype wire

// [verif/usbmc_engine_model.sv]
/* Engine and bus side of the control block: live SE0 level, SETUP pulse.
   Assumes the bench asks for each event; one request cycle, one pulse. */
`timescale 1ns/1ps
`default_nettype none
module usbmc_engine_model
(
    input wire logic aclk,
    input wire logic se0_req,
    input wire logic setup_req,
    output logic se0_line,
    output logic setup_token
);
    // Bus level changes off the clock edge, as a real line would
    assign #3 se0_line = se0_req;
    // One-cycle token pulse in the aclk domain; one driver only
    always @(posedge aclk)
        setup_token <= setup_req;
endmodule
`default_nettype wire

// [verif/testbench.sv]
/* Self-checking bench: firmware-style register traffic over AXI4-Lite.
   Assumes the package, the rtl modules and the engine model are built. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [15:0] ca = usbmc_pkg::CTRL_ADDR;
    localparam logic [15:0] sa = usbmc_pkg::IRQ_STAT_ADDR;
    localparam logic [15:0] ma = usbmc_pkg::IRQ_MASK_ADDR;
    localparam logic [15:0] fa = usbmc_pkg::CFG_ADDR;
    localparam logic [1:0] ok = usbmc_pkg::RESP_OKAY;
    localparam logic [1:0] err = usbmc_pkg::RESP_SLVERR;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic se0_req = 1'b0, setup_req = 1'b0, se0_line, setup_token;
    logic engine_enable, pullup_on, bd_pingpong_indicator_clear, pp_hold_even, pkt_halt;
    logic stat_fifo_retain, resume_drive, engine_clk_run, xcvr_idle, irq;
    int failures = 0, checked = 0, pulses = 0;

    always #12.5 aclk = ~aclk;
    // Indicator-clear is a one-cycle pulse, so count it as it passes
    always @(posedge aclk)
        if (bd_pingpong_indicator_clear === 1'b1) pulses <= pulses + 1;

    usbmc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .se0_line, .setup_token,
        .engine_enable, .pullup_on, .bd_pingpong_indicator_clear, .pp_hold_even, .pkt_halt,
        .stat_fifo_retain, .resume_drive, .engine_clk_run, .xcvr_idle, .irq);
    usbmc_engine_model far (.aclk, .se0_req, .setup_req, .se0_line,
        .setup_token);

    // ---------------------------------------------------------------
    // Checking and bus tasks
    // ---------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e,
        input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic outs(input logic [8:0] e);
        cmp("outputs", {23'h0, e}, {23'h0, engine_enable, pullup_on,
            pp_hold_even, pkt_halt, stat_fifo_retain, resume_drive,
            engine_clk_run, xcvr_idle, irq});
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
        input logic [1:0] er);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        if (i == 40)
        begin
            failures++;
            conclude();
        end
        cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge aclk);
    endtask
    task automatic rdr(input logic [15:0] a, input logic [7:0] e,
        input logic [1:0] er);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        if (i == 40)
        begin
            failures++;
            conclude();
        end
        cmp("rdata", {24'h0, e}, s_axi_rdata);
        cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        @(posedge aclk);
    endtask

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(ca, 8'h00, ok);
        outs(9'h000);
        $display("end reset test");
        wr(fa, 8'h01, ok);
        wr(ca, 8'h08, ok);
        outs(9'b110000100);
        cmp("pingpong_indicator pulses", 32'h1, pulses);
        wr(ca, 8'hff, ok);
        rdr(ca, 8'h4e, ok);
        outs(9'b110001000);
        wr(fa, 8'h03, ok);
        wr(ca, 8'h4a, ok);
        outs(9'b111000010);
        wr(ca, 8'h48, ok);
        wr(ca, 8'h08, ok);
        outs(9'b110000100);
        $display("end control test");
        wr(ma, 8'h01, ok);
        setup_req <= 1'b1;
        @(posedge aclk);
        setup_req <= 1'b0;
        repeat (3) @(posedge aclk);
        rdr(ca, 8'h18, ok);
        outs(9'b110110101);
        rdr(sa, 8'h01, ok);
        wr(ca, 8'h18, ok);
        rdr(ca, 8'h18, ok);
        wr(ca, 8'h08, ok);
        rdr(ca, 8'h08, ok);
        wr(sa, 8'h01, ok);
        outs(9'b110000100);
        $display("end setup test");
        se0_req <= 1'b1;
        repeat (4) @(posedge aclk);
        rdr(ca, 8'h28, ok);
        se0_req <= 1'b0;
        repeat (4) @(posedge aclk);
        rdr(ca, 8'h08, ok);
        rdr(sa, 8'h02, ok);
        $display("end se0 test");
        rdr(16'h0000, 8'h00, err);
        wr(16'h0000, 8'hff, err);
        wr(ca, 8'h46, ok);
        outs(9'h000);
        rdr(ca, 8'h46, ok);
        $display("end disable test");
        conclude();
    end
endmodule
`default_nettype wire
